// ### verilog/pagpio_regs.vh
// Register map, field positions and reset values of the port block
`ifndef PAGPIO_REGS_VH
`define PAGPIO_REGS_VH
`define PAG_OFF_PORT_PIN_DATA     8'h05
`define PAG_OFF_OPEN_DRAIN_ENABLE 8'h16
`define PAG_OFF_PIN_DIRECTION     8'h85
`define PAG_OFF_PULL_UP_ENABLE    8'h95
`define PAG_OFF_CHANGE_IRQ_ENABLE 8'h96
`define PAG_OFF_PULL_DOWN_ENABLE  8'h98
`define PAG_OFF_IRQ_CONTROL       8'h8B
`define PAG_OFF_IRQ_FLAG          8'h8C
`define PAG_OFF_PERIPH_CTRL       8'h9C
`define PAG_IDX_TO_BYTE(i)        ({(i), 2'b00})
`define PAG_NPINS                 6
`define PAG_BIT_INPUT_ONLY        3
`define PAG_BIT_PORT_CHANGE_FLAG  3
`define PAG_BIT_PORT_CHANGE_IE    3
`define PAG_BIT_GLOBAL_IE         7
`define PAG_BIT_MASTER_CLEAR_FUNCTION_EN           6
`define PAG_RST_DIRECTION         6'h3F
`define PAG_RST_ZERO6             6'h00
`define PAG_MASK_OPEN_DRAIN       6'h37
`define PAG_MASK_PULL_DOWN        6'h07
`define PAG_RESP_OKAY             2'b00
`define PAG_RESP_SLVERR           2'b10
`endif

// ### verilog/pagpio_port.v
// Six-pin GPIO port with change detection behind an AXI4-Lite slave
// Functional notes
// [R01] Six pins, each with direction and data bits
// [R02] Direction 1 makes pin input, driver off
// [R03] Direction 0 drives pin from output latch
// [R04] Pin 3 input only, direction reads one
// [R05] Data read gives pins; write loads latch
// [R06] Writes are read-modify-write into latch; the code loads the written byte whole
// [R07] Master clear on: pin 3 reads zero
// [R08] Per-pin pull-up enables, off at reset
// [R09] Per-pin change enables, cleared at reset
// [R10] Enabled pins compared with last-read snapshot
// [R11] Persisting mismatch keeps setting change flag
// [R12] Data register access refreshes the snapshot
// [R13] Change interrupt wakes device from sleep
// [R14] Global enable gates change interrupt
// [R15] Software disables change on programming pins
// [R16] Software sets programming clock pin input
// [R17] Open-drain enables, pin 3 unimplemented
// [R18] Pull-downs only on pins 2 to 0
// [R19] Enabled peripheral takes over its pin
// [R20] Change flag bit 3, sticky until cleared
// [R21] Global enable bit 7; zero disables all
// [R22] Request when flag, enable, global all set
`timescale 1ns/10ps
`include "pagpio_regs.vh"
`default_nettype none
module pagpio_port (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire [9:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [9:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire [5:0]  pin_in,
  output wire [5:0]  pin_out,
  output wire [5:0]  pin_oe,
  output wire [5:0]  pull_up_on,
  output wire [5:0]  pull_down_on,
  input  wire [5:0]  periph_own,
  input  wire [5:0]  periph_out,
  input  wire [5:0]  periph_oe,
  input  wire        sleep_active,
  output wire        port_change_irq,
  output wire        wake_req
);
  reg  [5:0] sync1_r;
  reg  [5:0] pin_sync_r;
  reg  [5:0] latch_r;
  reg  [5:0] dir_r;
  reg  [5:0] open_drain_r;
  reg  [5:0] pull_up_r;
  reg  [5:0] pull_dn_r;
  reg  [5:0] change_en_r;
  reg  [5:0] snap_r;
  reg        flag_r;
  reg  [7:0] irq_ctrl_r;
  reg        master_clear_function_en_r;
  reg  [9:0] awaddr_r;
  reg        aw_have_r;
  reg  [31:0] wdata_r;
  reg  [3:0] wstrb_r;
  reg        w_have_r;
  wire       do_write;
  wire       do_read;
  wire [5:0] pin_level;
  wire [5:0] dir_eff;
  wire [5:0] mismatch;
  wire       wr_data_hit;
  wire       rd_data_hit;
  wire       flag_clear;
  reg  [31:0] rd_val;
  reg         rd_ok;

  // Register index of a byte address; misaligned maps to an unused index
  function [7:0] reg_idx;
    input [9:0] addr;
    begin
      reg_idx = (addr[1:0] == 2'b00) ? addr[9:2] : 8'hFF;
    end
  endfunction

  // Register match test used by both channels
  function hit;
    input [9:0] addr;
    input [7:0] off;
    begin
      hit = (reg_idx(addr) == off);
    end
  endfunction

  function [5:0] byte0;
    input [31:0] d;
    begin
      byte0 = d[5:0];
    end
  endfunction

  // Pins pass a two-stage synchroniser
  always @(posedge aclk) begin
    if (!aresetn) begin
      sync1_r    <= `PAG_RST_ZERO6;
      pin_sync_r <= `PAG_RST_ZERO6;
    end else begin
      sync1_r    <= pin_in;
      pin_sync_r <= sync1_r;
    end
  end

  assign dir_eff = dir_r | (6'h01 << `PAG_BIT_INPUT_ONLY); // R04
  assign pin_level = {pin_sync_r[5:4],
                      pin_sync_r[3] & ~master_clear_function_en_r, // R07
                      pin_sync_r[2:0]}; // R05

  // Pad drive: open drain only pulls low; peripherals win
  genvar g;
  generate
    for (g = 0; g < `PAG_NPINS; g = g + 1) begin : g_pad // R01
      wire gp_oe = ~dir_eff[g] & (~open_drain_r[g] | ~latch_r[g]); // R02 R03 R17
      assign pin_out[g] = periph_own[g] ? periph_out[g] : (latch_r[g] & ~open_drain_r[g]); // R19
      assign pin_oe[g]  = periph_own[g] ? periph_oe[g] : gp_oe; // R19
    end
  endgenerate

  assign pull_up_on   = pull_up_r; // R08
  assign pull_down_on = pull_dn_r & `PAG_MASK_PULL_DOWN; // R18

  // AXI write channel: address and data taken in either order
  assign s_axi_awready = ~aw_have_r & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_have_r & ~s_axi_bvalid;
  assign do_write      = aw_have_r & w_have_r & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;
  assign do_read       = s_axi_arvalid & s_axi_arready;

  assign wr_data_hit = do_write && wstrb_r[0] && hit(awaddr_r, `PAG_OFF_PORT_PIN_DATA);
  assign rd_data_hit = do_read && hit(s_axi_araddr, `PAG_OFF_PORT_PIN_DATA);
  assign flag_clear  = do_write && wstrb_r[0] && hit(awaddr_r, `PAG_OFF_IRQ_FLAG) &&
                       !wdata_r[`PAG_BIT_PORT_CHANGE_FLAG];

  assign mismatch = (pin_level ^ snap_r) & change_en_r; // R10

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_r    <= 1'b0;
      w_have_r     <= 1'b0;
      awaddr_r     <= 10'h000;
      wdata_r      <= 32'h0000_0000;
      wstrb_r      <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `PAG_RESP_OKAY;
      latch_r      <= `PAG_RST_ZERO6;
      dir_r        <= `PAG_RST_DIRECTION;
      open_drain_r <= `PAG_RST_ZERO6; // R17
      pull_up_r    <= `PAG_RST_ZERO6; // R08
      pull_dn_r    <= `PAG_RST_ZERO6; // R18
      change_en_r  <= `PAG_RST_ZERO6; // R09
      irq_ctrl_r   <= 8'h00;
      master_clear_function_en_r    <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_r <= 1'b1;
        awaddr_r  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_r <= 1'b1;
        wdata_r  <= s_axi_wdata;
        wstrb_r  <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_have_r    <= 1'b0;
        w_have_r     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= `PAG_RESP_OKAY;
        if (wstrb_r[0]) begin
          case (reg_idx(awaddr_r))
            `PAG_OFF_PORT_PIN_DATA: begin
              // No read-modify-write: the written byte loads the whole latch, input pins included
              latch_r <= byte0(wdata_r); // R05 R06
            end
            `PAG_OFF_OPEN_DRAIN_ENABLE: open_drain_r <= byte0(wdata_r) & `PAG_MASK_OPEN_DRAIN; // R17
            `PAG_OFF_PIN_DIRECTION: dir_r <= byte0(wdata_r); // R01
            `PAG_OFF_PULL_UP_ENABLE: pull_up_r <= byte0(wdata_r); // R08
            `PAG_OFF_CHANGE_IRQ_ENABLE: change_en_r <= byte0(wdata_r); // R09
            `PAG_OFF_PULL_DOWN_ENABLE: pull_dn_r <= byte0(wdata_r) & `PAG_MASK_PULL_DOWN; // R18
            `PAG_OFF_IRQ_CONTROL: irq_ctrl_r <= wdata_r[7:0]; // R21
            `PAG_OFF_IRQ_FLAG: begin
            end
            `PAG_OFF_PERIPH_CTRL: master_clear_function_en_r <= wdata_r[`PAG_BIT_MASTER_CLEAR_FUNCTION_EN];
            default: s_axi_bresp <= `PAG_RESP_SLVERR;
          endcase
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Snapshot and sticky change flag; a live mismatch beats a clear
  always @(posedge aclk) begin
    if (!aresetn) begin
      snap_r <= `PAG_RST_ZERO6;
      flag_r <= 1'b0;
    end else begin
      if (rd_data_hit || wr_data_hit) begin
        snap_r <= pin_level; // R12
      end
      if (|mismatch) begin
        flag_r <= 1'b1; // R10 R11 R20
      end else if (flag_clear) begin
        flag_r <= 1'b0; // R20
      end
    end
  end

  // Read decode
  always @* begin
    rd_val = 32'h0000_0000;
    rd_ok  = 1'b1;
    case (reg_idx(s_axi_araddr))
      `PAG_OFF_PORT_PIN_DATA:     rd_val[5:0] = pin_level; // R05
      `PAG_OFF_OPEN_DRAIN_ENABLE: rd_val[5:0] = open_drain_r;
      `PAG_OFF_PIN_DIRECTION:     rd_val[5:0] = dir_eff; // R04
      `PAG_OFF_PULL_UP_ENABLE:    rd_val[5:0] = pull_up_r;
      `PAG_OFF_CHANGE_IRQ_ENABLE: rd_val[5:0] = change_en_r;
      `PAG_OFF_PULL_DOWN_ENABLE:  rd_val[5:0] = pull_dn_r;
      `PAG_OFF_IRQ_CONTROL:       rd_val[7:0] = irq_ctrl_r;
      `PAG_OFF_IRQ_FLAG:          rd_val[`PAG_BIT_PORT_CHANGE_FLAG] = flag_r;
      `PAG_OFF_PERIPH_CTRL:       rd_val[`PAG_BIT_MASTER_CLEAR_FUNCTION_EN] = master_clear_function_en_r;
      default:                    rd_ok = 1'b0;
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `PAG_RESP_OKAY;
    end else if (do_read) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_val;
      s_axi_rresp  <= rd_ok ? `PAG_RESP_OKAY : `PAG_RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  assign port_change_irq = flag_r & irq_ctrl_r[`PAG_BIT_PORT_CHANGE_IE] &
                           irq_ctrl_r[`PAG_BIT_GLOBAL_IE]; // R14 R21 R22
  assign wake_req = sleep_active & flag_r & irq_ctrl_r[`PAG_BIT_PORT_CHANGE_IE]; // R13
endmodule // pagpio_port
`default_nettype wire

// ### test/pagpio_chk_assertions.sv
// Bus handshake, pad control and wake properties of the port
`timescale 1ns/10ps
`default_nettype none
module pagpio_chk (
  input wire logic       aclk,
  input wire logic       aresetn,
  input wire logic       s_axi_awready,
  input wire logic       s_axi_bvalid,
  input wire logic       s_axi_bready,
  input wire logic       s_axi_arready,
  input wire logic       s_axi_rvalid,
  input wire logic       s_axi_rready,
  input wire logic [5:0] pin_oe,
  input wire logic [5:0] pull_down_on,
  input wire logic       sleep_active,
  input wire logic       port_change_irq,
  input wire logic       wake_req
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  in_only_a: assert property (pin_oe[3] == 1'b0) else $error("pin 3 driven");
  pd_mask_a: assert property (pull_down_on[5:3] == 3'b000) else $error("bad pull-down");
  wake_src_a: assert property (wake_req |-> sleep_active) else $error("wake awake");
  irq_wake_a: assert property (port_change_irq && sleep_active |-> wake_req) else $error("no wake");
  b_drop_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid) else $error("b held");
  r_drop_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid) else $error("r held");
  ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("ar open");
  aw_block_a: assert property (s_axi_bvalid |-> !s_axi_awready) else $error("aw open");
endmodule // pagpio_chk
bind pagpio_port pagpio_chk u_chk (.*);
`default_nettype wire

// ### test/pagpio_pins.sv
// Pad model: buttons pull to ground; unpulled idle pins toggle
`timescale 1ns/10ps
`default_nettype none
module pagpio_pins (
  input  wire logic       aclk,
  input  wire logic [5:0] pin_out,
  input  wire logic [5:0] pin_oe,
  input  wire logic [5:0] pull_up_on,
  input  wire logic [5:0] pull_down_on,
  input  wire logic [5:0] press,
  output var  logic [5:0] pin_in
);
  logic flt = 1'b0;
  always @(posedge aclk) flt <= ~flt;
  always_comb begin
    for (int i = 0; i < 6; i++) begin
      pin_in[i] = pin_oe[i] ? pin_out[i] : press[i] ? 1'b0 :
                  pull_up_on[i] ? 1'b1 : pull_down_on[i] ? 1'b0 : flt;
    end
  end
endmodule // pagpio_pins
`default_nettype wire

// ### test/port_a_gpio_with_change_irq_tb.sv
// Bench: bus access, pad levels and change detection of the port
`timescale 1ns/10ps
`default_nettype none
module port_a_gpio_with_change_irq_tb;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
  logic        s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic        s_axi_rvalid, sleep_active, port_change_irq, wake_req, ta, tw, tr, dn;
  logic [9:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rdv;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
  logic [5:0]  pin_in, pin_out, pin_oe, pull_up_on, pull_down_on, press;
  logic [5:0]  periph_own, periph_out, periph_oe;
  integer      error_cnt, checks_done, cyc;
  pagpio_port dut (.*);
  pagpio_pins pins (.*);
  always #20 aclk = ~aclk;
  task automatic end_sim;
    $display("errors %0d checks %0d", error_cnt, checks_done);
    if (error_cnt == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      error_cnt++;
      end_sim();
    end
  end
  task automatic chk(input logic [31:0] g, e);
    checks_done++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // One bus access; each channel released at the edge that takes it
  task automatic acc(input logic w, input logic [7:0] a, d);
    @(posedge aclk);
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} <= {a, 2'b00, a, 2'b00, 24'h00_0000, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} <= {w, w, w, !w, !w};
    dn = 1'b0;
    while (!dn) begin
      @(negedge aclk);
      ta = s_axi_awvalid & s_axi_awready;
      tw = s_axi_wvalid & s_axi_wready;
      tr = s_axi_arvalid & s_axi_arready;
      dn = w ? s_axi_bvalid : s_axi_rvalid;
      {rsp, rdv} = w ? {s_axi_bresp, 32'h0000_0000} : {s_axi_rresp, s_axi_rdata};
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      if (tr) s_axi_arvalid <= 1'b0;
    end
    {s_axi_bready, s_axi_rready} <= 2'b00;
  endtask
  task automatic rc(input logic [7:0] a, e);
    acc(1'b0, a, 8'h00);
    chk(rdv, {24'h00_0000, e});
  endtask
  task automatic t_reset;
    rc(8'h85, 8'h3F);
    rc(8'h95, 8'h00);
    rc(8'h96, 8'h00);
    rc(8'h16, 8'h00);
    rc(8'h98, 8'h00);
  endtask
  task automatic t_pads;
    acc(1'b1, 8'h95, 8'h3F);
    acc(1'b1, 8'h05, 8'h25);
    chk(pin_oe, 6'h00);
    acc(1'b1, 8'h85, 8'h00);
    rc(8'h85, 8'h08);
    chk({pin_oe, pin_out & 6'h37}, {6'h37, 6'h25});
    rc(8'h05, 8'h2D);
    acc(1'b1, 8'h16, 8'h3F);
    rc(8'h16, 8'h37);
    chk({pin_oe, pin_out & pin_oe}, {6'h12, 6'h00});
    acc(1'b1, 8'h85, 8'h3F);
    acc(1'b1, 8'h98, 8'h3F);
    rc(8'h98, 8'h07);
    chk({pull_up_on, pull_down_on}, {6'h3F, 6'h07});
  endtask
  task automatic t_change;
    acc(1'b1, 8'h96, 8'h01);
    acc(1'b1, 8'h8B, 8'h88);
    rc(8'h05, 8'h3F);
    sleep_active <= 1'b1;
    press <= 6'h02;
    repeat (4) @(negedge aclk);
    chk(port_change_irq, 1'b0);
    @(posedge aclk);
    press <= 6'h03;
    repeat (4) @(negedge aclk);
    chk({port_change_irq, wake_req}, 2'b11);
    acc(1'b1, 8'h8C, 8'h00);
    chk(port_change_irq, 1'b1);
    rc(8'h8C, 8'h08);
    rc(8'h05, 8'h3C);
    acc(1'b1, 8'h8C, 8'h00);
    chk(port_change_irq, 1'b0);
    acc(1'b1, 8'h8B, 8'h08);
    press <= 6'h02;
    repeat (4) @(negedge aclk);
    chk({port_change_irq, wake_req}, 2'b01);
  endtask
  task automatic t_misc;
    acc(1'b1, 8'h9C, 8'h40);
    rc(8'h05, 8'h35);
    periph_own <= 6'h01;
    periph_oe <= 6'h01;
    @(negedge aclk);
    chk({pin_oe[0], pin_out[0]}, 2'b10);
    acc(1'b0, 8'h40, 8'h00);
    chk({rsp, rdv}, {2'b10, 32'h0000_0000});
    acc(1'b1, 8'h40, 8'h00);
    chk(rsp, 2'b10);
  endtask
  initial begin
    {aclk, aresetn, sleep_active, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {press, periph_own, periph_out, periph_oe} = '0;
    {error_cnt, checks_done, cyc} = '0;
    s_axi_wstrb = 4'h1;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_pads();
    t_change();
    t_misc();
    end_sim();
  end
endmodule // port_a_gpio_with_change_irq_tb
`default_nettype wire
